// ===== design/slt_regs.svh
// Timing counts and code constants of the serial link transmitter
`ifndef SLT_REGS_SVH
`define SLT_REGS_SVH

// ==========================================
// Clocking
`define SLT_CLK_PERIOD_NS 20
`define SLT_BITS_PER_CHAR 10
`define SLT_BIT_CNT_W 4
`define SLT_BIT_CNT_LAST 4'h9
`define SLT_BWC_LEAD 4'h8

// ==========================================
// Read pulse duty
`define SLT_RP_LOW_PCT 60
`define SLT_RP_LOW_CYCLES ((`SLT_RP_LOW_PCT * `SLT_BITS_PER_CHAR) / 100)

// ==========================================
// Characters, written a first (MSB) to j last (LSB)
`define SLT_K28_5_BYTE 8'hBC
`define SLT_K28_X 5'h1C
`define SLT_K28_6B 6'h0F
`define SLT_ALT_4B 4'h7
`define SLT_VIOL_CODE 10'h0F1
`define SLT_RESET_RD 1'b0

`endif

// ===== design/slt_pkg.sv
// Types of the serial link transmitter
package slt_pkg;

	typedef enum logic {
		SLT_ENCODED = 1'b0,
		SLT_BYPASS = 1'b1
	} slt_mode_t;

	typedef struct packed {
		logic pad;
		slt_mode_t mode;
		logic ctx;
		logic viol;
		logic [7:0] data;
	} slt_inword_t;

endpackage

// ===== design/slt_char_if.sv
// Character hand-off between word logic and output shifter
`timescale 1ns/1ps
interface slt_char_if;
	logic load;
	logic [9:0] char_lsb_first;
	logic ser_bit;

	modport src (
		output load,
		output char_lsb_first,
		input ser_bit
	);

	modport shf (
		input load,
		input char_lsb_first,
		output ser_bit
	);
endinterface

// ===== design/slt_sync2.sv
// Two-stage synchroniser for static control pins
`timescale 1ns/1ps
module slt_sync2 #(
	parameter int W = 2
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Data
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	logic [W-1:0] stage1;

	// ==========================================
	// Stage one feeds stage two only
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge clock_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					stage1[g] <= 1'b0;
					sync_o[g] <= 1'b0;
				end else begin
					stage1[g] <= async_i[g];
					sync_o[g] <= stage1[g];
				end
			end
		end
	endgenerate

endmodule

// ===== design/slt_shifter.sv
// Ten-bit output shifter, bit a leaves first
`timescale 1ns/1ps
module slt_shifter (
	// Clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Character port
	slt_char_if.shf ch
);

	logic [9:0] sh;

	// ==========================================
	// Load on byte edge, then one bit per clock
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sh <= 10'h000;
		end else if (ch.load) begin
			sh <= ch.char_lsb_first;
		end else begin
			sh <= {1'b0, sh[9:1]};
		end
	end

	assign ch.ser_bit = sh[0];

endmodule

// ===== design/slt_tx_top.sv
// Serial link transmitter: input register, 8B/10B encoder, pads, outputs
`timescale 1ns/1ps
`include "slt_regs.svh"

// Contract
// - Input word captured into input register on byte write clock edge, both modes.
// - Word accepted only when at least one active-low strobe is low.
// - Read pulse low about 60% of each byte while early strobe is low.
// - Encoded mode: eight data, context and violation bits become ten-bit code.
// - Context low selects data set, high selects special set.
// - Special C0.7 or violation request produces a violation symbol.
// - Bypass: ten inputs sent raw, context first bit, violation last.
// - Held character moves to shifter on next byte edge, one bit per clock.
// - First bit appears on every pair not held by kill one clock after the byte edge of the transfer.
// - Both strobes high at byte edge sends a K28.5 pad.
// - Bypass: first pad disparity may be wrong, following pads correct.
// - All three pairs carry the same stream except under kill.
// - Kill holds first and second pairs true low, complement high.
// - All-zero bypass characters drive serial outputs low continuously.
// - Bit rate is ten times the byte rate, one character per byte.
module slt_tx_top (
	// Clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Host parallel word
	input wire logic [7:0] data_i,
	input wire logic char_context_i,
	input wire logic violation_request_i,
	input wire logic input_strobe_early_n_i,
	input wire logic input_strobe_next_n_i,
	// Static control pins
	input wire logic bypass_mode_i,
	input wire logic output_kill_i,
	// Host timing
	output logic byte_write_clock_o,
	output logic fifo_read_pulse_n_o,
	// Serial pairs
	output logic serial_pair_first_p_o,
	output logic serial_pair_first_n_o,
	output logic serial_pair_second_p_o,
	output logic serial_pair_second_n_o,
	output logic serial_pair_third_p_o,
	output logic serial_pair_third_n_o
);

	// ==========================================
	// Declarations
	logic [`SLT_BIT_CNT_W-1:0] bit_cnt;
	logic byte_edge;
	logic [1:0] pins_sync;
	logic mode_bypass;
	logic kill;
	slt_pkg::slt_inword_t in_reg;
	logic word_taken;
	logic rd;
	logic [9:0] enc_code;
	logic enc_rd;
	logic [9:0] next_code;
	logic next_rd;
	logic [9:0] code_lsb_first;
	slt_char_if ch ();

	// ==========================================
	// 5b/6b data table, RD- column, abcdei
	function automatic logic [5:0] tab6(input logic [4:0] x);
		logic [5:0] c;
		c = 6'h00;
		case (x)
			5'h00: c = 6'h27;
			5'h01: c = 6'h1D;
			5'h02: c = 6'h2D;
			5'h03: c = 6'h31;
			5'h04: c = 6'h35;
			5'h05: c = 6'h29;
			5'h06: c = 6'h19;
			5'h07: c = 6'h38;
			5'h08: c = 6'h39;
			5'h09: c = 6'h25;
			5'h0A: c = 6'h15;
			5'h0B: c = 6'h34;
			5'h0C: c = 6'h0D;
			5'h0D: c = 6'h2C;
			5'h0E: c = 6'h1C;
			5'h0F: c = 6'h17;
			5'h10: c = 6'h1B;
			5'h11: c = 6'h23;
			5'h12: c = 6'h13;
			5'h13: c = 6'h32;
			5'h14: c = 6'h0B;
			5'h15: c = 6'h2A;
			5'h16: c = 6'h1A;
			5'h17: c = 6'h3A;
			5'h18: c = 6'h33;
			5'h19: c = 6'h26;
			5'h1A: c = 6'h16;
			5'h1B: c = 6'h36;
			5'h1C: c = 6'h0E;
			5'h1D: c = 6'h2E;
			5'h1E: c = 6'h1E;
			default: c = 6'h2B;
		endcase
		return c;
	endfunction

	// ==========================================
	// 3b/4b table, RD- column, fghj
	function automatic logic [3:0] tab4(input logic [2:0] y);
		logic [3:0] c;
		c = 4'h0;
		case (y)
			3'h0: c = 4'hB;
			3'h1: c = 4'h9;
			3'h2: c = 4'h5;
			3'h3: c = 4'hC;
			3'h4: c = 4'hD;
			3'h5: c = 4'hA;
			3'h6: c = 4'h6;
			default: c = 4'hE;
		endcase
		return c;
	endfunction

	// ==========================================
	// Byte divider; byte_edge is the byte write clock edge
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bit_cnt <= '0;
		end else if (byte_edge) begin
			bit_cnt <= '0;
		end else begin
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	assign byte_edge = (bit_cnt == `SLT_BIT_CNT_LAST);

	// Registered from count 8, so the host sees the pulse in the same cycle as the capture
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			byte_write_clock_o <= 1'b0;
		end else begin
			byte_write_clock_o <= (bit_cnt == `SLT_BWC_LEAD);
		end
	end

	// ==========================================
	// Read pulse: low for the first part of each byte
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fifo_read_pulse_n_o <= 1'b1;
		end else if (input_strobe_early_n_i) begin
			fifo_read_pulse_n_o <= 1'b1;
		end else if (byte_edge) begin
			fifo_read_pulse_n_o <= 1'b0;
		end else begin
			fifo_read_pulse_n_o <= (bit_cnt >= 4'(`SLT_RP_LOW_CYCLES - 1));
		end
	end

	// ==========================================
	// Static pins pass a synchroniser
	slt_sync2 #(
		.W(2)
	) u_sync (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.async_i({bypass_mode_i, output_kill_i}),
		.sync_o(pins_sync)
	);

	assign mode_bypass = pins_sync[1];
	assign kill = pins_sync[0];

	// ==========================================
	// Input register
	assign word_taken = !input_strobe_early_n_i || !input_strobe_next_n_i;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			in_reg.pad <= 1'b1;
			in_reg.mode <= slt_pkg::SLT_ENCODED;
			in_reg.ctx <= 1'b1;
			in_reg.viol <= 1'b0;
			in_reg.data <= `SLT_K28_5_BYTE;
		end else if (byte_edge) begin
			in_reg.mode <= mode_bypass ? slt_pkg::SLT_BYPASS : slt_pkg::SLT_ENCODED;
			if (word_taken) begin
				in_reg.pad <= 1'b0;
				in_reg.ctx <= char_context_i;
				in_reg.viol <= violation_request_i;
				in_reg.data <= data_i;
			end else begin
				in_reg.pad <= 1'b1;
				in_reg.ctx <= 1'b1;
				in_reg.viol <= 1'b0;
				in_reg.data <= `SLT_K28_5_BYTE;
			end
		end
	end

	// ==========================================
	// 8B/10B encoder
	always_comb begin
		logic [4:0] x;
		logic [2:0] y;
		logic k;
		logic k28;
		logic k_ok;
		logic [5:0] c6;
		logic [3:0] c4;
		logic unbal6;
		logic unbal4;
		logic rd_mid;
		logic alt;
		logic inv4;
		k28 = 1'b0;
		k_ok = 1'b0;
		c6 = 6'h00;
		c4 = 4'h0;
		unbal6 = 1'b0;
		unbal4 = 1'b0;
		rd_mid = 1'b0;
		alt = 1'b0;
		inv4 = 1'b0;
		x = in_reg.data[4:0];
		y = in_reg.data[7:5];
		k = in_reg.ctx;
		k28 = k && (x == `SLT_K28_X);
		k_ok = k28 || (k && (y == 3'h7) &&
			(x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E));
		c6 = k28 ? `SLT_K28_6B : tab6(x);
		unbal6 = ($countones(c6) != 3);
		if (rd && (unbal6 || (!k && x == 5'h07))) begin
			c6 = ~c6;
		end
		rd_mid = rd ^ unbal6;
		alt = (y == 3'h7) && (k || (!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14))
			|| (rd_mid && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
		c4 = alt ? `SLT_ALT_4B : tab4(y);
		unbal4 = ($countones(c4) != 2);
		inv4 = rd_mid && (unbal4 || y == 3'h3);
		if (k28 && !unbal4 && y != 3'h3) begin
			inv4 = !rd_mid;
		end
		c4 = inv4 ? ~c4 : c4;
		enc_code = {c6, c4};
		enc_rd = rd_mid ^ unbal4;
		// Violation is balanced so disparity carries through unchanged
		if (in_reg.viol || (k && !k_ok)) begin
			enc_code = rd ? ~`SLT_VIOL_CODE : `SLT_VIOL_CODE;
			enc_rd = rd;
		end
	end

	// ==========================================
	// Mode selection of the outgoing character
	always_comb begin
		next_code = enc_code;
		next_rd = enc_rd;
		if (in_reg.mode == slt_pkg::SLT_BYPASS && !in_reg.pad) begin
			// Raw character; disparity is not tracked, so a first pad may be off
			next_code = {in_reg.ctx, in_reg.data[0], in_reg.data[1], in_reg.data[2],
				in_reg.data[3], in_reg.data[4], in_reg.data[5], in_reg.data[6],
				in_reg.data[7], in_reg.viol};
			next_rd = rd;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd <= `SLT_RESET_RD;
		end else if (byte_edge) begin
			rd <= next_rd;
		end
	end

	// ==========================================
	// Hand-off to shifter, bit a first
	genvar g;
	generate
		for (g = 0; g < `SLT_BITS_PER_CHAR; g++) begin : g_rev
			assign code_lsb_first[g] = next_code[`SLT_BITS_PER_CHAR-1-g];
		end
	endgenerate

	assign ch.load = byte_edge;
	assign ch.char_lsb_first = code_lsb_first;

	slt_shifter u_shifter (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.ch(ch)
	);

	// ==========================================
	// Output pairs, registered from the shifter bit
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			serial_pair_third_p_o <= 1'b0;
			serial_pair_third_n_o <= 1'b1;
		end else begin
			serial_pair_third_p_o <= ch.ser_bit;
			serial_pair_third_n_o <= !ch.ser_bit;
		end
	end

	// Kill forces only the first two; third stays as diagnostic feedback
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			serial_pair_first_p_o <= 1'b0;
			serial_pair_first_n_o <= 1'b1;
			serial_pair_second_p_o <= 1'b0;
			serial_pair_second_n_o <= 1'b1;
		end else if (kill) begin
			serial_pair_first_p_o <= 1'b0;
			serial_pair_first_n_o <= 1'b1;
			serial_pair_second_p_o <= 1'b0;
			serial_pair_second_n_o <= 1'b1;
		end else begin
			serial_pair_first_p_o <= ch.ser_bit;
			serial_pair_first_n_o <= !ch.ser_bit;
			serial_pair_second_p_o <= ch.ser_bit;
			serial_pair_second_n_o <= !ch.ser_bit;
		end
	end

endmodule

// ===== sim/slt_host_model.sv
// Host FIFO model feeding one word per byte clock
`timescale 1ns/1ps
module slt_host_model (
	// Clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Byte timing and staged word
	input wire logic byte_clock_i,
	input wire logic [11:0] stage_i,
	// Strobes, context, violation, data
	output logic [11:0] word_o
);
	// Word moves only at a byte edge, so it stands the whole byte
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			word_o <= 12'hC00;
		end else if (byte_clock_i) begin
			word_o <= stage_i;
		end
	end
endmodule

// ===== sim/slt_tx_props.sv
// Port checker of the serial link transmitter
`timescale 1ns/1ps
module slt_tx_props (
	// Clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Host side
	input wire logic [7:0] data_i,
	input wire logic char_context_i,
	input wire logic violation_request_i,
	input wire logic input_strobe_early_n_i,
	input wire logic input_strobe_next_n_i,
	input wire logic bypass_mode_i,
	input wire logic output_kill_i,
	input wire logic byte_write_clock_o,
	input wire logic fifo_read_pulse_n_o,
	// Serial pairs
	input wire logic serial_pair_first_p_o,
	input wire logic serial_pair_first_n_o,
	input wire logic serial_pair_second_p_o,
	input wire logic serial_pair_second_n_o,
	input wire logic serial_pair_third_p_o,
	input wire logic serial_pair_third_n_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	sequence gap_s; !byte_write_clock_o [*8] ##1 !byte_write_clock_o; endsequence
	sequence early_s; !input_strobe_early_n_i [*6]; endsequence
	// Kill passes two sync stages and the output register
	sequence kill_s; output_kill_i [*4]; endsequence
	sequence live_s; !output_kill_i [*4]; endsequence
	byte_period_a: assert property (byte_write_clock_o |=> gap_s ##1 byte_write_clock_o)
		else $error("byte clock period wrong");
	rp_forced_a: assert property (input_strobe_early_n_i |=> fifo_read_pulse_n_o)
		else $error("read pulse low without strobe");
	rp_start_a: assert property (byte_write_clock_o && !input_strobe_early_n_i
		|=> !fifo_read_pulse_n_o)
		else $error("read pulse late");
	rp_len_a: assert property (byte_write_clock_o ##0 early_s
		|=> !fifo_read_pulse_n_o ##1 fifo_read_pulse_n_o)
		else $error("read pulse length wrong");
	rp_high_a: assert property (byte_write_clock_o |-> fifo_read_pulse_n_o)
		else $error("read pulse low at byte edge");
	kill_hold_a: assert property (kill_s |->
		!serial_pair_first_p_o && serial_pair_first_n_o &&
		!serial_pair_second_p_o && serial_pair_second_n_o)
		else $error("killed pairs not held");
	pair_same_a: assert property (live_s |->
		serial_pair_first_p_o == serial_pair_third_p_o &&
		serial_pair_second_p_o == serial_pair_third_p_o)
		else $error("pairs differ");
	pair_compl_a: assert property (live_s |->
		serial_pair_first_n_o != serial_pair_first_p_o &&
		serial_pair_second_n_o != serial_pair_second_p_o)
		else $error("pair legs not complementary");
	third_compl_a: assert property (serial_pair_third_n_o != serial_pair_third_p_o)
		else $error("third pair legs equal");
endmodule
bind slt_tx_top slt_tx_props chk (.*);

// ===== sim/slt_tx_top_tb_top.sv
// Testbench of the serial link transmitter
`timescale 1ns/1ps
module slt_tx_top_tb_top;
	logic clock_i, arst_n_i, bypass_mode_i, output_kill_i;
	logic [7:0] data_i;
	logic char_context_i, violation_request_i, input_strobe_early_n_i, input_strobe_next_n_i;
	logic byte_write_clock_o, fifo_read_pulse_n_o;
	logic serial_pair_first_p_o, serial_pair_first_n_o, serial_pair_second_p_o;
	logic serial_pair_second_n_o, serial_pair_third_p_o, serial_pair_third_n_o;
	logic [11:0] stage;
	logic [11:0] host_word;
	logic [9:0] c1, c2, c3;
	logic rd;
	int failures, total_checks, lows;
	slt_tx_top dut (.*);
	slt_host_model host (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.byte_clock_i(byte_write_clock_o),
		.stage_i(stage),
		.word_o(host_word)
	);
	assign {input_strobe_early_n_i, input_strobe_next_n_i, char_context_i, violation_request_i,
		data_i} = host_word;
	// ==========================================
	// Shared tasks
	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cmp10(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Stage a word, then stop at the byte edge that hands it to the host
	task automatic put(input logic [11:0] w);
		int i;
		@(posedge clock_i);
		stage <= w;
		#1;
		for (i = 0; i < 40 && byte_write_clock_o !== 1'b1; i++) begin
			@(posedge clock_i);
			#1;
		end
		if (i == 40) begin
			failures++;
			print_verdict();
		end else begin
			@(posedge clock_i);
		end
	endtask
	// Collect one character, a first; skip 20 reaches the word just put
	task automatic gather(input int skip, output logic [9:0] c);
		repeat (skip) @(posedge clock_i);
		for (int k = 9; k >= 0; k--) begin
			@(posedge clock_i);
			#1;
			c[k] = serial_pair_third_p_o;
			lows += (fifo_read_pulse_n_o === 1'b0);
			if (output_kill_i) cmp10(10'({serial_pair_first_p_o, serial_pair_first_n_o,
				serial_pair_second_p_o, serial_pair_second_n_o}), 10'h005);
			else cmp10(10'({serial_pair_first_p_o, serial_pair_second_p_o, serial_pair_first_n_o}),
				10'({c[k], c[k], ~c[k]}));
		end
	endtask
	// ==========================================
	// Scenarios
	task automatic test_pads();
		put(12'hC00);
		lows = 0;
		gather(20, c1);
		gather(0, c2);
		cmp10(10'(c1 == 10'h0FA || c1 == 10'h305), 10'h001);
		cmp10(c1 ^ c2, 10'h3FF);
		cmp10(10'(lows), 10'h000);
		$display("pads done");
	endtask
	task automatic test_data();
		put(12'h400);
		lows = 0;
		gather(20, c1);
		gather(0, c2);
		rd = (c1 == 10'h18B);
		cmp10(10'(c1 == 10'h274 || rd), 10'h001);
		cmp10(c2, c1);
		cmp10(10'(lows), 10'h00C);
		put(12'h500);
		gather(20, c1);
		cmp10(c1, rd ? 10'h30E : 10'h0F1);
		put(12'h6E0);
		gather(20, c1);
		cmp10(c1, rd ? 10'h30E : 10'h0F1);
		put(12'h6FB);
		gather(20, c1);
		cmp10(c1, rd ? 10'h097 : 10'h368);
		put(12'h800);
		gather(20, c1);
		cmp10(c1, rd ? 10'h18B : 10'h274);
		put(12'hC00);
		gather(20, c1);
		cmp10(c1, rd ? 10'h305 : 10'h0FA);
		$display("encoded done");
	endtask
	task automatic test_bypass();
		@(posedge clock_i);
		bypass_mode_i <= 1'b1;
		put(12'h735);
		gather(20, c1);
		cmp10(c1, 10'h359);
		put(12'h400);
		gather(20, c1);
		cmp10(c1, 10'h000);
		@(posedge clock_i);
		output_kill_i <= 1'b1;
		put(12'h735);
		gather(20, c1);
		cmp10(c1, 10'h359);
		@(posedge clock_i);
		output_kill_i <= 1'b0;
		put(12'hC00);
		gather(20, c1);
		gather(0, c2);
		gather(0, c3);
		cmp10(10'(c1 == 10'h0FA || c1 == 10'h305), 10'h001);
		cmp10(10'(c2 == 10'h0FA || c2 == 10'h305), 10'h001);
		cmp10(c2 ^ c3, 10'h3FF);
		$display("bypass done");
	endtask
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	initial begin
		arst_n_i = 1'b0;
		bypass_mode_i = 1'b0;
		output_kill_i = 1'b0;
		stage = 12'hC00;
		failures = 0;
		total_checks = 0;
		lows = 0;
		repeat (20) @(posedge clock_i);
		arst_n_i <= 1'b1;
		test_pads();
		test_data();
		test_bypass();
		print_verdict();
	end
endmodule
